//--- verilog/door_access_pkg.sv
// shared constants and types for the door access mode logic
package door_access_pkg;

  // ********
  // sizes and special schedules
  // ********
  localparam int NUM_DOORS = 2; // two doors, two reader ports
  localparam logic [7:0] OPEN_SCHEDULE = 8'h00; // always open schedule number
  localparam logic [7:0] AUTO_UNLOCK_SCHEDULE = 8'hc8; // schedule 200, auto unlock
  localparam int HOLIDAY_DAY = 8; // holiday entry of each schedule
  localparam int HOLIDAY_DEPTH = 16; // holiday table entries

  // ********
  // timing
  // ********
  localparam int CLK_PERIOD_NS = 50; // sys_clk period
  localparam int SECOND_NS = 1000000000; // one second in ns
  localparam int TICKS_PER_SECOND = SECOND_NS / CLK_PERIOD_NS;
  localparam int STRAP_SETTLE = 3; // cycles before jumpers are caught

  // ********
  // serial default settings
  // ********
  localparam int SERIAL_BAUD = 9600; // forced baud rate
  localparam int CLK_HZ = TICKS_PER_SECOND;
  localparam logic [11:0] SERIAL_BAUD_DIV = 12'(CLK_HZ / SERIAL_BAUD);
  localparam logic [3:0] SERIAL_DATA_BITS = 4'h8; // forced data bits
  localparam logic SERIAL_PARITY_ON = 1'b0; // no parity

  // ********
  // enumerations
  // ********
  typedef enum logic [1:0] {MODE_NORMAL, MODE_LOCKDOWN, MODE_PASSAGE} doorMode_type;
  typedef enum logic [1:0] {CARD_ACCESS, CARD_LOCKDOWN, CARD_FORCE_OPEN,
                            CARD_END_FORCED} cardKind_type;
  typedef enum logic [1:0] {HOST_NONE, HOST_LOCKDOWN, HOST_PASSAGE,
                            HOST_NORMAL} hostOp_type;

  // ********
  // carriers
  // ********
  typedef struct packed {
    logic valid; // one-cycle card read
    cardKind_type kind; // access card or control card
    logic [7:0] schedule; // card's schedule number
    logic weekdayPermit; // today's weekday entry covers now
    logic holidayPermit; // day 8 entry covers now
  } cardEvent_type;

  typedef struct packed {
    hostOp_type op; // forced mode request
    logic door; // door index
  } hostCmd_type;

  typedef struct packed {
    logic weekdayActive; // schedule 200 weekday entry covers now
    logic holidayActive; // schedule 200 day 8 entry covers now
  } unlockWindow_type;

  typedef struct packed {
    logic [6:0] year; // year offset
    logic [3:0] month;
    logic [4:0] day;
  } calDate_type;

  typedef struct packed {
    logic valid;
    logic recurring; // match every year
    calDate_type date;
  } holidayEntry_type;

  typedef struct packed {
    logic d0; // first input line
    logic d1; // second input line
  } readerLines_type;

  typedef struct packed {
    logic wiegandD0;
    logic wiegandD1;
    logic abaClock;
    logic abaData;
    logic barcode;
  } readerSignals_type;

  typedef struct packed {
    logic learnFitted;
    logic usbSelect;
    logic rs422Select;
    logic onlinePortFitted;
    logic serialDefaultFitted;
  } jumpers_type;

  typedef struct packed {
    logic learnMode;
    logic usbActive;
    logic rs422Active;
    logic onlineNetwork;
    logic serialOverride;
    logic [11:0] baudDiv;
    logic [3:0] dataBits;
    logic parityOn;
  } portConfig_type;

endpackage : door_access_pkg

//--- verilog/holiday_match.sv
// holiday table with recurring and one-off date matching
`timescale 1ns/100ps
module holiday_match
  import door_access_pkg::*;
#(
  parameter int DEPTH = HOLIDAY_DEPTH
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // table write
  input wire logic wrEn,
  input wire logic [$clog2(DEPTH)-1:0] wrIndex,
  input wire holidayEntry_type wrEntry,
  // calendar
  input wire calDate_type today,
  output logic isHoliday_q
);

  initial begin
    if (DEPTH < 2) $error("DEPTH must be at least 2");
  end

  holidayEntry_type table_q [DEPTH];   // programmed holidays
  logic [DEPTH-1:0] hit;               // per entry match

  // table storage
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < DEPTH; i++) table_q[i] <= '0;
    end else if (wrEn) begin
      table_q[wrIndex] <= wrEntry;
    end
  end

  // recurring ignores the year, one-off needs it too
  for (genvar g = 0; g < DEPTH; g++) begin : gMatch
    assign hit[g] = table_q[g].valid
                 && table_q[g].date.month == today.month
                 && table_q[g].date.day == today.day
                 && (table_q[g].recurring || table_q[g].date.year == today.year);
  end

  // registered holiday flag
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) isHoliday_q <= 1'b0;
    else isHoliday_q <= |hit;
  end

endmodule : holiday_match

//--- verilog/door_release_timer.sv
// momentary unlock timer counting whole seconds
`timescale 1ns/100ps
module door_release_timer
  import door_access_pkg::*;
#(
  parameter int TICKS = TICKS_PER_SECOND
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // control
  input wire logic start,
  input wire logic abort,
  input wire logic [7:0] seconds,
  output logic active_q
);

  initial begin
    if (TICKS < 1) $error("TICKS must be positive");
  end

  logic [31:0] tick_q;    // prescaler within one second
  logic [7:0] secLeft_q;  // seconds still to run

  // prescaler and second countdown; a fresh start restarts the period
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      tick_q <= '0;
      secLeft_q <= '0;
      active_q <= 1'b0;
    end else if (abort) begin
      tick_q <= '0;
      secLeft_q <= '0;
      active_q <= 1'b0;
    end else if (start) begin
      tick_q <= '0;
      secLeft_q <= (seconds == 8'h00) ? 8'h01 : seconds;
      active_q <= 1'b1;
    end else if (active_q) begin
      if (tick_q == 32'(TICKS - 1)) begin
        tick_q <= '0;
        secLeft_q <= secLeft_q - 8'h01;
        if (secLeft_q == 8'h01) active_q <= 1'b0;
      end else begin
        tick_q <= tick_q + 32'h1;
      end
    end
  end

endmodule : door_release_timer

//--- verilog/door_mode_access_control.sv
// per-door access modes, schedules, holidays, jumpers and reader routing
// Notes on behaviour
// - holiday start releases relay, uses day 8
// - on holidays grant only day 8 or schedule 0
// - recurring holidays yearly, others exact date only
// - first-person-in: stay locked at unlock start
// - first valid read unlocks until period ends
// - valid read means grantable without unlock period
// - without first-person-in unlock at period start
// - lockdown by host command or lockdown card
// - lockdown grants only schedule 0 cards
// - lockdown ends by host or end card
// - passage by host command or force-open card
// - passage holds door unlocked until changed
// - resume normal returns to schedules and cards
// - remote release unlocks for unlock cycle time
// - learn jumper absent at power-up: learn mode
// - sample host port selection jumpers
// - online jumper picks network or serial path
// - serial default forces 9600, 8 bits, no parity
// - port 1 lines: D0/clock/barcode, D1/data
// - port 2 lines: D0/clock, D1/data, no barcode
// - green and second LED output per port
// - forced modes suppress scheduled auto unlock
// - schedule 0 always open, holidays included
// - schedule 200 drives automatic unlock, day 8 holidays
`timescale 1ns/100ps
module door_mode_access_control
  import door_access_pkg::*;
#(
  parameter int DOORS = NUM_DOORS,
  parameter int TICKS = TICKS_PER_SECOND,
  parameter int HOL_DEPTH = HOLIDAY_DEPTH
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,

  // host management requests
  input wire hostCmd_type hostCmd,

  // decoded card reads, one per reader port
  input wire cardEvent_type [DOORS-1:0] cardEvent,

  // automatic unlock schedule windows
  input wire unlockWindow_type [DOORS-1:0] unlockWindow,

  // per door options
  input wire logic [DOORS-1:0] firstPersonIn,
  input wire logic [DOORS-1:0][7:0] unlockSeconds,

  // holiday table and calendar
  input wire logic holWrEn,
  input wire logic [$clog2(HOL_DEPTH)-1:0] holWrIndex,
  input wire holidayEntry_type holWrEntry,
  input wire calDate_type today,

  // pins: remote release switches, jumpers, reader lines
  input wire logic [DOORS-1:0] remoteReleasePin,
  input wire jumpers_type jumperPins,
  input wire readerLines_type [DOORS-1:0] readerPins,

  // door outputs
  output logic [DOORS-1:0] relay_q,
  output doorMode_type [DOORS-1:0] doorMode_q,
  output logic [DOORS-1:0] grant_q,
  output logic [DOORS-1:0] deny_q,
  output logic holiday_q,

  // reader port outputs
  output readerSignals_type [DOORS-1:0] readerSignals_q,
  output logic [DOORS-1:0] ledGreen_q,
  output logic [DOORS-1:0] ledSecond_q,

  // host port selection
  output portConfig_type portConfig_q
);

  // parameter checks
  initial begin
    if (DOORS != 2) $error("two doors only");
    if (TICKS < 1) $error("TICKS must be positive");
  end

  // ********
  // pin synchronisers
  // ********

  logic [DOORS-1:0] releaseMeta_q; // first stage, remote release
  logic [DOORS-1:0] releaseSync_q; // second stage
  logic [DOORS-1:0] releasePrev_q; // for edge detection

  jumpers_type jumperMeta_q; // first stage, jumpers
  jumpers_type jumperSync_q; // second stage

  readerLines_type [DOORS-1:0] readerMeta_q; // first stage, reader lines
  readerLines_type [DOORS-1:0] readerSync_q; // second stage

  // two flops on every pin
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      releaseMeta_q <= '0;
      releaseSync_q <= '0;
      releasePrev_q <= '0;
      jumperMeta_q <= '0;
      jumperSync_q <= '0;
      readerMeta_q <= '0;
      readerSync_q <= '0;
    end else begin
      releaseMeta_q <= remoteReleasePin;
      releaseSync_q <= releaseMeta_q;
      releasePrev_q <= releaseSync_q;
      jumperMeta_q <= jumperPins;
      jumperSync_q <= jumperMeta_q;
      readerMeta_q <= readerPins;
      readerSync_q <= readerMeta_q;
    end
  end

  // ********
  // power-up jumper capture
  // ********

  logic [1:0] settle_q;   // cycles since reset release
  logic captured_q;       // jumpers caught once

  // wait for the synchroniser to fill, then latch once
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      settle_q <= '0;
      captured_q <= 1'b0;
    end else if (!captured_q) begin
      if (settle_q == 2'(STRAP_SETTLE - 1)) captured_q <= 1'b1;
      else settle_q <= settle_q + 2'h1;
    end
  end

  // host port selection from the caught jumpers
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      portConfig_q <= '0;
    end else if (!captured_q && settle_q == 2'(STRAP_SETTLE - 1)) begin
      portConfig_q.learnMode <= ~jumperSync_q.learnFitted;
      portConfig_q.usbActive <= jumperSync_q.usbSelect;
      portConfig_q.rs422Active <= jumperSync_q.rs422Select;
      // removed serial jumper forces serial as online port
      if (!jumperSync_q.serialDefaultFitted) begin
        portConfig_q.serialOverride <= 1'b1;
        portConfig_q.onlineNetwork <= 1'b0;
      end else begin
        portConfig_q.serialOverride <= 1'b0;
        portConfig_q.onlineNetwork <= jumperSync_q.onlinePortFitted;
      end
      portConfig_q.baudDiv <= SERIAL_BAUD_DIV;
      portConfig_q.dataBits <= SERIAL_DATA_BITS;
      portConfig_q.parityOn <= SERIAL_PARITY_ON;
    end
  end

  // ********
  // holidays
  // ********

  logic holPrev_q; // holiday flag one cycle ago
  logic holidayNow; // registered holiday match
  logic holidayStart; // first cycle of a holiday period

  holiday_match #(
    .DEPTH(HOL_DEPTH)
  ) uHoliday (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .wrEn(holWrEn),
    .wrIndex(holWrIndex),
    .wrEntry(holWrEntry),
    .today(today),
    .isHoliday_q(holidayNow)
  );

  assign holidayStart = holidayNow & ~holPrev_q;

  // holiday edge and mirrored output
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      holPrev_q <= 1'b0;
      holiday_q <= 1'b0;
    end else begin
      holPrev_q <= holidayNow;
      holiday_q <= holidayNow;
    end
  end

  // ********
  // per door logic
  // ********

  for (genvar d = 0; d < DOORS; d++) begin : gDoor

    // card handling
    logic hostHit; // host request aimed at this door
    logic cardIn; // card read on this door's reader
    logic openCard; // card on the always open schedule
    logic schedPermit; // card's own schedule covers now
    logic wouldGrant; // grant as if no unlock period ran
    logic cardGrant; // access card granted now

    // scheduled unlock
    logic windowRaw; // schedule 200 window for today
    logic window; // window after forced mode suppression
    logic windowPrev_q; // window one cycle ago
    logic windowStart; // first cycle of a window
    logic fpiOpen_q; // window opened by a valid read
    logic schedOpen; // scheduled unlock in force

    // momentary unlock
    logic releaseEdge; // remote release switch closed
    logic timerStart; // start of momentary unlock
    logic timerActive; // momentary unlock running

    doorMode_type modeNext; // mode after this cycle's requests

    assign hostHit = hostCmd.op != HOST_NONE && hostCmd.door == 1'(d);
    assign cardIn = cardEvent[d].valid;
    assign openCard = cardEvent[d].schedule == OPEN_SCHEDULE;

    // day 8 entry on holidays, weekday entry otherwise
    assign schedPermit = holidayNow ? cardEvent[d].holidayPermit
                                    : cardEvent[d].weekdayPermit;
    assign wouldGrant = openCard || schedPermit;

    // lockdown lets only schedule 0 cards through
    assign cardGrant = cardIn && cardEvent[d].kind == CARD_ACCESS
                    && (doorMode_q[d] == MODE_LOCKDOWN ? openCard
                                                       : wouldGrant);

    // forced mode requests, host first then control card
    always_comb begin
      modeNext = doorMode_q[d];
      if (hostHit) begin
        unique case (hostCmd.op)
          HOST_LOCKDOWN: modeNext = MODE_LOCKDOWN;
          HOST_PASSAGE: modeNext = MODE_PASSAGE;
          HOST_NORMAL: modeNext = MODE_NORMAL;
          HOST_NONE: modeNext = doorMode_q[d];
        endcase
      end else if (cardIn) begin
        unique case (cardEvent[d].kind)
          CARD_LOCKDOWN: modeNext = MODE_LOCKDOWN;
          CARD_FORCE_OPEN: modeNext = MODE_PASSAGE;
          CARD_END_FORCED: modeNext = MODE_NORMAL;
          CARD_ACCESS: modeNext = doorMode_q[d];
        endcase
      end
    end

    // mode register, latest request wins, host over card in the same cycle
    always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) doorMode_q[d] <= MODE_NORMAL;
      else doorMode_q[d] <= modeNext;
    end

    // schedule 200 window, holiday entry on holidays
    assign windowRaw = holidayNow ? unlockWindow[d].holidayActive
                                  : unlockWindow[d].weekdayActive;
    assign window = windowRaw && doorMode_q[d] == MODE_NORMAL;
    assign windowStart = window && !windowPrev_q;

    // first-person-in latch, dropped at window end or holiday start
    always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
        windowPrev_q <= 1'b0;
        fpiOpen_q <= 1'b0;
      end else begin
        windowPrev_q <= window;
        if (!window || holidayStart) fpiOpen_q <= 1'b0;
        else if (windowStart) fpiOpen_q <= 1'b0;
        else if (cardIn && cardEvent[d].kind == CARD_ACCESS && wouldGrant)
          fpiOpen_q <= 1'b1;
      end
    end

    // immediate or delayed scheduled unlock
    assign schedOpen = firstPersonIn[d] ? fpiOpen_q
                                        : window && !holidayStart;

    assign releaseEdge = releaseSync_q[d] && !releasePrev_q[d];
    assign timerStart = releaseEdge || cardGrant;

    door_release_timer #(
      .TICKS(TICKS)
    ) uTimer (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .start(timerStart),
      .abort(holidayStart),
      .seconds(unlockSeconds[d]),
      .active_q(timerActive)
    );

    // relay drive and read outcome
    always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
        relay_q[d] <= 1'b0;
        grant_q[d] <= 1'b0;
        deny_q[d] <= 1'b0;
      end else begin
        relay_q[d] <= modeNext == MODE_PASSAGE
                   || (doorMode_q[d] == MODE_NORMAL && schedOpen)
                   || (timerActive && !holidayStart);
        grant_q[d] <= cardGrant;
        deny_q[d] <= cardIn && cardEvent[d].kind == CARD_ACCESS && !cardGrant;
      end
    end

    // green shows an open door, second LED flags a refusal
    always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
        ledGreen_q[d] <= 1'b0;
        ledSecond_q[d] <= 1'b0;
      end else begin
        ledGreen_q[d] <= relay_q[d];
        ledSecond_q[d] <= deny_q[d];
      end
    end

  end

  // ********
  // reader line routing
  // ********

  // first line carries D0 or clock, second D1 or data
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      readerSignals_q <= '0;
    end else begin
      for (int p = 0; p < DOORS; p++) begin
        // D0, D1, clock, data, barcode; barcode on the first port only
        readerSignals_q[p] <= '{readerSync_q[p].d0, readerSync_q[p].d1,
          readerSync_q[p].d0, readerSync_q[p].d1,
          (p == 0) ? readerSync_q[p].d0 : 1'b0};
      end
    end
  end

endmodule : door_mode_access_control

//--- test/door_partner.sv
// reader and remote release switch model for the door block
`timescale 1ns/100ps
module door_partner
  import door_access_pkg::*;
(
  // clock and requests from the bench
  input wire logic sys_clk,
  input wire logic press,
  // pins toward the block
  output readerLines_type [1:0] lines,
  output logic [1:0] sw
);
  // ****
  // behaviour
  // ****
  logic [3:0] lfsr = 4'h1; // line pattern, changes every cycle
  logic [2:0] held = 3'h0; // switch closure cycles left
  // readers chatter so stale values never look valid
  always @(posedge sys_clk) begin
    lfsr <= {lfsr[2:0], lfsr[3] ^ lfsr[2]};
    held <= press ? 3'h6 : (held != 3'h0 ? held - 3'h1 : 3'h0);
  end
  assign lines = lfsr;
  assign sw = {1'b0, held != 3'h0}; // door 0 switch closed while held
endmodule : door_partner

//--- test/door_mode_sva.sv
// port assertions for the door mode block
`timescale 1ns/100ps
module door_mode_sva
  import door_access_pkg::*;
#(
  parameter int DOORS = NUM_DOORS
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // requests
  input wire hostCmd_type hostCmd,
  input wire cardEvent_type [DOORS-1:0] cardEvent,
  input wire readerLines_type [DOORS-1:0] readerPins,
  // results
  input wire logic [DOORS-1:0] relay_q,
  input wire doorMode_type [DOORS-1:0] doorMode_q,
  input wire logic [DOORS-1:0] grant_q,
  input wire logic [DOORS-1:0] deny_q,
  input wire readerSignals_type [DOORS-1:0] readerSignals_q,
  input wire logic [DOORS-1:0] ledGreen_q,
  input wire logic [DOORS-1:0] ledSecond_q,
  input wire portConfig_type portConfig_q
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  logic [2:0] age_q; // cycles since reset, saturating
  logic hostIdle; // no host request for door 0
  logic ctlCard; // control card on door 0
  // age counter keeps history checks out of reset
  always_ff @(posedge sys_clk or negedge reset_n)
    if (!reset_n) age_q <= 3'h0;
    else if (age_q != 3'h7) age_q <= age_q + 3'h1;
  assign hostIdle = hostCmd.op == HOST_NONE || hostCmd.door;
  assign ctlCard = cardEvent[0].valid && cardEvent[0].kind != CARD_ACCESS;
  property p_passage;
    hostCmd.op == HOST_PASSAGE && !hostCmd.door |=> doorMode_q[0] == MODE_PASSAGE && relay_q[0];
  endproperty
  a_passage: assert property (p_passage) else $error("passage request ignored");
  property p_lock;
    (hostCmd.op == HOST_LOCKDOWN && !hostCmd.door) || (hostIdle && ctlCard
      && cardEvent[0].kind == CARD_LOCKDOWN) |=> doorMode_q[0] == MODE_LOCKDOWN;
  endproperty
  a_lock: assert property (p_lock) else $error("lockdown ignored");
  property p_normal;
    hostCmd.op == HOST_NORMAL && !hostCmd.door |=> doorMode_q[0] == MODE_NORMAL;
  endproperty
  a_normal: assert property (p_normal) else $error("resume ignored");
  property p_hold;
    doorMode_q[0] == MODE_PASSAGE && hostIdle && !ctlCard
      |=> doorMode_q[0] == MODE_PASSAGE && relay_q[0];
  endproperty
  a_hold: assert property (p_hold) else $error("passage not held");
  property p_lockdeny;
    doorMode_q[0] == MODE_LOCKDOWN && hostIdle && cardEvent[0].valid
      && cardEvent[0].kind == CARD_ACCESS && cardEvent[0].schedule != OPEN_SCHEDULE
      |=> deny_q[0] && !grant_q[0];
  endproperty
  a_lockdeny: assert property (p_lockdeny) else $error("card passed lockdown");
  property p_open;
    cardEvent[0].valid && cardEvent[0].kind == CARD_ACCESS
      && cardEvent[0].schedule == OPEN_SCHEDULE |=> grant_q[0] && !deny_q[0];
  endproperty
  a_open: assert property (p_open) else $error("open card denied");
  property p_led;
    age_q != 3'h0 |-> ledGreen_q == $past(relay_q) && ledSecond_q == $past(deny_q);
  endproperty
  a_led: assert property (p_led) else $error("leds not following");
  property p_port1;
    age_q == 3'h7 |-> {readerSignals_q[0].barcode, readerSignals_q[0].wiegandD0,
      readerSignals_q[0].abaClock} == {3{$past(readerPins[0].d0, 3)}}
      && {readerSignals_q[0].wiegandD1, readerSignals_q[0].abaData}
      == {2{$past(readerPins[0].d1, 3)}};
  endproperty
  a_port1: assert property (p_port1) else $error("port 1 routing");
  property p_port2;
    !readerSignals_q[1].barcode && (age_q != 3'h7
      || {readerSignals_q[1].wiegandD0, readerSignals_q[1].abaClock,
      readerSignals_q[1].wiegandD1, readerSignals_q[1].abaData}
      == {{2{$past(readerPins[1].d0, 3)}}, {2{$past(readerPins[1].d1, 3)}}});
  endproperty
  a_port2: assert property (p_port2) else $error("port 2 routing");
  property p_serial;
    age_q == 3'h7 && portConfig_q.serialOverride |-> portConfig_q.baudDiv == SERIAL_BAUD_DIV
      && portConfig_q.dataBits == SERIAL_DATA_BITS && !portConfig_q.parityOn
      && !portConfig_q.onlineNetwork;
  endproperty
  a_serial: assert property (p_serial) else $error("serial defaults wrong");
endmodule : door_mode_sva
bind door_mode_access_control door_mode_sva #(.DOORS(DOORS)) u_sva (
  .sys_clk(sys_clk), .reset_n(reset_n), .hostCmd(hostCmd), .cardEvent(cardEvent),
  .readerPins(readerPins), .relay_q(relay_q), .doorMode_q(doorMode_q), .grant_q(grant_q),
  .deny_q(deny_q), .readerSignals_q(readerSignals_q), .ledGreen_q(ledGreen_q),
  .ledSecond_q(ledSecond_q), .portConfig_q(portConfig_q)
);

//--- test/tb.sv
// self-checking bench for the door mode block
`timescale 1ns/100ps
module tb;
  import door_access_pkg::*;
  localparam int TK = 10; // short second
  logic sys_clk = 1'b0, reset_n = 1'b0;
  hostCmd_type hostCmd = '0;
  cardEvent_type [1:0] cardEvent = '0;
  unlockWindow_type [1:0] win = '0;
  logic [1:0] fpi = 2'h0;
  logic [1:0][7:0] secs = {8'h01, 8'h01};
  logic holWrEn = 1'b0;
  logic [3:0] holIdx = 4'h0;
  holidayEntry_type holEnt = '0;
  calDate_type today = '{7'h05, 4'h3, 5'h0a};
  jumpers_type jmp = '0;
  logic press = 1'b0;
  logic [1:0] rel, relay, grant, deny, ledG, ledS;
  readerLines_type [1:0] rdPins;
  doorMode_type [1:0] mode;
  logic hol;
  readerSignals_type [1:0] rsig;
  portConfig_type pcfg;
  doorMode_type expMode = MODE_NORMAL;
  jumpers_type j;
  int mismatches = 0, check_count = 0, seed = 53, n;
  always #25 sys_clk = ~sys_clk;
  door_mode_access_control #(.TICKS(TK)) u_dut (
    .sys_clk, .reset_n, .hostCmd, .cardEvent, .unlockWindow(win), .firstPersonIn(fpi),
    .unlockSeconds(secs), .holWrEn, .holWrIndex(holIdx), .holWrEntry(holEnt), .today,
    .remoteReleasePin(rel),
    .jumperPins(jmp), .readerPins(rdPins), .relay_q(relay), .doorMode_q(mode),
    .grant_q(grant), .deny_q(deny), .holiday_q(hol), .readerSignals_q(rsig),
    .ledGreen_q(ledG), .ledSecond_q(ledS), .portConfig_q(pcfg)
  );
  door_partner u_partner (.sys_clk(sys_clk), .press(press), .lines(rdPins), .sw(rel));
  task automatic step(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask : step
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (e !== g) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop
  task automatic host(input hostOp_type op);
    hostCmd = '{op, 1'b0};
    step(1);
    hostCmd.op = HOST_NONE;
  endtask : host
  task automatic card(input logic [7:0] s, input logic w);
    cardEvent[0] = '{1'b1, CARD_ACCESS, s, w, 1'b0};
    step(1);
    cardEvent[0].valid = 1'b0;
  endtask : card
  task automatic hol_write(input logic [3:0] i, input holidayEntry_type e);
    holWrEn = 1'b1;
    holIdx = i;
    holEnt = e;
    step(1);
    holWrEn = 1'b0;
  endtask : hol_write
  function automatic doorMode_type next_mode(doorMode_type m, hostOp_type op, cardEvent_type c);
    if (op == HOST_LOCKDOWN) return MODE_LOCKDOWN;
    if (op == HOST_PASSAGE) return MODE_PASSAGE;
    if (op == HOST_NORMAL) return MODE_NORMAL;
    if (!c.valid || c.kind == CARD_ACCESS) return m;
    if (c.kind == CARD_LOCKDOWN) return MODE_LOCKDOWN;
    if (c.kind == CARD_FORCE_OPEN) return MODE_PASSAGE;
    return MODE_NORMAL;
  endfunction : next_mode
  // random host requests and card reads on both doors
  task automatic rand_loop(input logic hl);
    hostOp_type op;
    cardEvent_type c;
    logic g, a;
    for (int i = 0; i < 40; i++) begin
      op = hostOp_type'(2'($random(seed)));
      c = cardEvent_type'(13'($random(seed)));
      if (c.schedule[7]) c.schedule = OPEN_SCHEDULE;
      a = c.valid && c.kind == CARD_ACCESS;
      if (a) op = HOST_NONE;
      g = a && (c.schedule == OPEN_SCHEDULE
        || (expMode != MODE_LOCKDOWN && (hl ? c.holidayPermit : c.weekdayPermit)));
      cardEvent = {cardEvent_type'(13'($random(seed))), c};
      hostCmd = '{op, 1'($random(seed))};
      if (hostCmd.door) op = HOST_NONE;
      step(1);
      expMode = next_mode(expMode, op, c);
      chk("mode", expMode, mode[0]);
      chk("grant", g, grant[0]);
      chk("deny", a && !g, deny[0]);
      if (expMode == MODE_PASSAGE) chk("passage relay", 1, relay[0]);
    end
    cardEvent = '0;
    host(HOST_NORMAL);
    expMode = MODE_NORMAL;
    step(3 * TK);
  endtask : rand_loop
  initial begin
    step(20);
    reset_n = 1'b1;
    step(4);
    win[0] = '{1'b1, 1'b0};
    step(2);
    chk("window relay", 1, relay[0]);
    host(HOST_LOCKDOWN);
    step(1);
    chk("lockdown relay", 0, relay[0]);
    host(HOST_NORMAL);
    step(1);
    chk("resume relay", 1, relay[0]);
    win[0] = '0;
    fpi[0] = 1'b1;
    step(2);
    win[0] = '{1'b1, 1'b0};
    step(3);
    chk("first in hold", 0, relay[0]);
    card(8'h05, 1'b0);
    step(1);
    chk("first in refused", 0, relay[0]);
    card(8'h05, 1'b1);
    step(3 * TK);
    chk("first in open", 1, relay[0]);
    win[0] = '0;
    step(2);
    chk("first in end", 0, relay[0]);
    fpi[0] = 1'b0;
    secs[0] = 8'h02;
    press = 1'b1;
    step(1);
    press = 1'b0;
    for (n = 0; n < 20 && relay[0] !== 1'b1; n++) step(1);
    chk("release relay", 1, relay[0]);
    if (relay[0] !== 1'b1) report_and_stop();
    for (n = 0; relay[0] === 1'b1 && n < 100; n++) step(1);
    chk("release time", 1, n >= 2 * TK - 1 && n <= 2 * TK + 2);
    rand_loop(1'b0);
    win[0] = '{1'b1, 1'b0};
    step(2);
    hol_write(4'h0, '{1'b1, 1'b0, '{7'h04, 4'h3, 5'h0a}});
    step(3);
    chk("one-off other year", 0, hol);
    hol_write(4'h1, '{1'b1, 1'b1, '{7'h04, 4'h3, 5'h0a}});
    step(3);
    chk("recurring", 1, hol);
    chk("holiday relay", 0, relay[0]);
    win[0] = '{1'b1, 1'b1};
    step(2);
    chk("holiday window", 1, relay[0]);
    win[0] = '0;
    rand_loop(1'b1);
    for (int k = 0; k < 4; k++) begin
      j = jumpers_type'(5'($random(seed)));
      j.serialDefaultFitted = k[0];
      jmp = j;
      reset_n = 1'b0;
      step(2);
      reset_n = 1'b1;
      step(5);
      chk("learn", !j.learnFitted, pcfg.learnMode);
      chk("port pick", {j.usbSelect, j.rs422Select}, {pcfg.usbActive, pcfg.rs422Active});
      chk("online", j.onlinePortFitted && j.serialDefaultFitted, pcfg.onlineNetwork);
      chk("override", !k[0], pcfg.serialOverride);
      if (!k[0])
        chk("serial", {12'h823, 4'h8, 1'b0}, {pcfg.baudDiv, pcfg.dataBits, pcfg.parityOn});
    end
    report_and_stop();
  end
endmodule : tb
